// [design/parallel_port_extended_control.sv]
// Overview of operation
// - The extended control register answers in every port mode.
// - Bits seven to five hold a read/write mode; code 101 is reserved.
// - Mode 000 is output-only standard port; FIFO held in reset.
// - Mode 001: direction tri-states data lines; data reads return live lines.
// - Mode 010: FIFO bytes sent with standard handshake, forward direction only.
// - Mode 011 forward: data and address queues share one FIFO, sent out.
// - Mode 011 reverse: peripheral bytes are stored in the data queue.
// - Mode 100 activates EPP operation when EPP is the chosen type.
// - Mode 110: host reads and writes FIFO; nothing is sent on the port.
// - Mode 111 maps both capability registers at indices 0x400 and 0x401.
// - Bit four low enables falling-edge error interrupt, in ECP mode only.
// - Reset: mode 000, mask set, DMA off, service set, not full, empty.
// - Service flag set by hardware on service event; software clears it.
// - Read-only bit one reports FIFO completely full.
// - Read-only bit zero reports FIFO completely empty.
//
// Our own choices: the APB register port and the address map.
`timescale 1ns/1ps

module parallel_port_extended_control
  import ppx_pkg::*;
(
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [DATA_W-1:0] pwdata,
  output logic [DATA_W-1:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic peripheral_error_in_n,
  input wire logic epp_selected,
  input wire logic dma_tc,
  input wire logic irq_line,
  input wire logic [7:0] pd_in,
  output logic [7:0] pd_out,
  output logic pd_oe,
  output logic tx_valid,
  output logic [7:0] tx_data,
  output logic tx_is_addr,
  input wire logic tx_ack,
  input wire logic rx_valid,
  input wire logic [7:0] rx_data,
  output logic rx_ack,
  output logic dma_req,
  output logic service_irq,
  output logic error_irq,
  output logic epp_active
);

  // ----------------------------------------------------------------
  // Decoding helpers
  // ----------------------------------------------------------------
  function automatic logic is_fifo_mode(input port_mode_t m);
    is_fifo_mode = (m == MODE_HWFIFO) || (m == MODE_ECP) || (m == MODE_TEST);
  endfunction

  function automatic logic [ADDR_W-1:0] idx_addr(input logic [10:0] idx);
    idx_addr = {idx, 2'b00};
  endfunction

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  apb_state_t st_q, st_d;
  port_mode_t mode_q, mode_d;
  logic mask_q, mask_d, dma_q, dma_d, svc_q, svc_d, dir_q, dir_d;
  logic [7:0] data_q, data_d, ctrl_q, ctrl_d;
  logic [2:0] capb_q, capb_d;
  logic [DATA_W-1:0] prdata_q, prdata_d;
  logic pready_q, pready_d, pslverr_q, pslverr_d, rd_pop_q, rd_pop_d;
  logic fault_q, err_irq_q, err_irq_d, svc_irq_q, svc_irq_d, dma_req_q, dma_req_d;
  logic [7:0] pd_out_q, pd_out_d, tx_data_q, tx_data_d;
  logic pd_oe_q, pd_oe_d, tx_valid_q, tx_valid_d, tx_addr_q, tx_addr_d;
  logic rx_ack_q, rx_ack_d, epp_q, epp_d;
  logic fifo_flush, fifo_push, fifo_pop, fifo_full, fifo_empty;
  logic [FIFO_W-1:0] fifo_push_data, fifo_head;
  logic [FIFO_AW:0] fifo_count, fifo_free;
  logic access, done, wr_done, hit, svc_event, sending, ecr_wr;
  port_mode_t wr_mode;

  ppx_byte_fifo u_fifo (
    .clk_sys(clk_sys),
    .rst(rst),
    .flush(fifo_flush),
    .push(fifo_push),
    .push_data(fifo_push_data),
    .pop(fifo_pop),
    .head(fifo_head),
    .full(fifo_full),
    .empty(fifo_empty),
    .count(fifo_count)
  );

  // ----------------------------------------------------------------
  // APB slave: one wait state, then the answer
  // ----------------------------------------------------------------
  // The answer is registered so every output comes from a flip-flop; the
  // cost is one extra cycle per transfer.
  always_comb
  begin
    access = psel && penable;
    done = access && pready_q;
    wr_done = done && pwrite;
    st_d = st_q;
    pready_d = 1'b0;
    pslverr_d = 1'b0;
    prdata_d = prdata_q;
    rd_pop_d = 1'b0;
    hit = 1'b1;
    unique case (st_q)
      APB_IDLE:
      begin
        if (access)
        begin
          st_d = APB_DONE;
          pready_d = 1'b1;
          prdata_d = '0;
          unique case (paddr)
            OFF_DATA: prdata_d[7:0] = (mode_q == MODE_BIDIR) ? pd_in : data_q;
            OFF_CTRL: prdata_d[7:0] = ctrl_q;
            OFF_ECR: prdata_d[7:0] = {mode_q, mask_q, dma_q, svc_q, fifo_full, fifo_empty};
            OFF_FIFO:
            begin
              hit = is_fifo_mode(mode_q);
              prdata_d[7:0] = fifo_head[7:0];
              rd_pop_d = !pwrite && !fifo_empty && ((mode_q == MODE_TEST) || (mode_q == MODE_ECP && dir_q));
            end
            OFF_AQUEUE: hit = (mode_q == MODE_ECP);
            idx_addr(IDX_CAP_A):
            begin
              hit = (mode_q == MODE_CFG);
              prdata_d[7:0] = CAP_A_VALUE;
            end
            idx_addr(IDX_CAP_B):
            begin
              hit = (mode_q == MODE_CFG);
              prdata_d[7:0] = {1'b0, irq_line, CAP_B_IRQ_SEL, capb_q};
            end
            default: hit = 1'b0;
          endcase
          pslverr_d = !hit;
          if (!hit)
          begin
            prdata_d = '0;
            rd_pop_d = 1'b0;
          end
        end
      end
      APB_DONE:
      begin
        st_d = APB_IDLE;
      end
      default:
      begin
        st_d = APB_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      st_q <= APB_IDLE;
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q <= '0;
      rd_pop_q <= 1'b0;
    end
    else
    begin
      st_q <= st_d;
      pready_q <= pready_d;
      pslverr_q <= pslverr_d;
      prdata_q <= prdata_d;
      rd_pop_q <= rd_pop_d;
    end
  end

  // ----------------------------------------------------------------
  // Register writes, FIFO traffic and port side
  // ----------------------------------------------------------------
  // Writes take effect only at the completing edge; the service flag sets
  // over a software clear in the same cycle so no event is lost.
  always_comb
  begin
    ecr_wr = wr_done && !pslverr_q && (paddr == OFF_ECR);
    wr_mode = port_mode_t'(pwdata[ECR_MODE_LSB +: 3]);
    mode_d = mode_q;
    mask_d = mask_q;
    dma_d = dma_q;
    svc_d = svc_q;
    data_d = data_q;
    ctrl_d = ctrl_q;
    capb_d = capb_q;
    if (ecr_wr)
    begin
      if (wr_mode != MODE_RSVD)
      begin
        mode_d = wr_mode;
      end
      mask_d = pwdata[ECR_MASK_BIT];
      dma_d = pwdata[ECR_DMA_BIT];
      if (!pwdata[ECR_SVC_BIT])
      begin
        svc_d = 1'b0;
      end
    end
    if (wr_done && !pslverr_q && paddr == OFF_DATA)
    begin
      data_d = pwdata[7:0];
    end
    if (wr_done && !pslverr_q && paddr == OFF_CTRL)
    begin
      ctrl_d = pwdata[7:0];
    end
    if (wr_done && !pslverr_q && paddr == idx_addr(IDX_CAP_B))
    begin
      capb_d = pwdata[2:0];
    end
    dir_d = ctrl_d[CTRL_DIR_BIT];
    // FIFO is held in reset in mode 000 and flushed by the write entering it.
    fifo_flush = (mode_q == MODE_SPP) || (ecr_wr && wr_mode == MODE_SPP);
    fifo_free = FIFO_DEPTH[FIFO_AW:0] - fifo_count;
    // Service events; with DMA on, terminal count; otherwise FIFO threshold.
    svc_event = is_fifo_mode(mode_q) && !svc_q &&
                (dma_q ? dma_tc : (dir_q ? (fifo_count >= SVC_THRESH) : (fifo_free >= SVC_THRESH)));
    if (svc_event)
    begin
      svc_d = 1'b1;
    end
    svc_irq_d = svc_event;
    dma_req_d = dma_d && !svc_d && is_fifo_mode(mode_q) && (dir_q ? !fifo_empty : !fifo_full);
    // Error interrupt on the falling edge, only in ECP mode and unmasked.
    err_irq_d = (mode_q == MODE_ECP) && !mask_q && fault_q && !peripheral_error_in_n;
    epp_d = (mode_q == MODE_EPP) && epp_selected;
    // Host pushes in forward modes and test mode; the peripheral in ECP reverse.
    sending = ((mode_q == MODE_HWFIFO) || (mode_q == MODE_ECP)) && !dir_q;
    fifo_push = 1'b0;
    fifo_push_data = {1'b0, pwdata[7:0]};
    rx_ack_d = 1'b0;
    if (wr_done && !pslverr_q && (paddr == OFF_FIFO) && (sending || mode_q == MODE_TEST))
    begin
      fifo_push = 1'b1;
    end
    else if (wr_done && !pslverr_q && (paddr == OFF_AQUEUE) && sending)
    begin
      fifo_push = 1'b1;
      fifo_push_data = {1'b1, pwdata[7:0]};
    end
    else if ((mode_q == MODE_ECP) && dir_q && rx_valid && !fifo_full)
    begin
      fifo_push = 1'b1;
      fifo_push_data = {1'b0, rx_data};
      rx_ack_d = 1'b1;
    end
    // Transmit stage takes the head whenever it is free and the mode sends.
    tx_valid_d = tx_valid_q && !tx_ack;
    tx_data_d = tx_data_q;
    tx_addr_d = tx_addr_q;
    fifo_pop = done && rd_pop_q;
    if (!tx_valid_d && sending && !fifo_empty && !fifo_flush)
    begin
      tx_valid_d = 1'b1;
      tx_data_d = fifo_head[7:0];
      tx_addr_d = fifo_head[8];
      fifo_pop = 1'b1;
    end
    // Data lines: driven unless direction reverses in a mode that allows it.
    pd_oe_d = (mode_d == MODE_SPP) || !dir_d;
    pd_out_d = sending ? tx_data_d : data_d;
  end

  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      mode_q <= MODE_SPP;
      mask_q <= ECR_MASK_RST;
      dma_q <= ECR_DMA_RST;
      svc_q <= ECR_SVC_RST;
      dir_q <= 1'b0;
      data_q <= '0;
      ctrl_q <= '0;
      capb_q <= CAP_B_LOW_RST;
      fault_q <= 1'b1;
      err_irq_q <= 1'b0;
      svc_irq_q <= 1'b0;
      dma_req_q <= 1'b0;
      epp_q <= 1'b0;
      tx_valid_q <= 1'b0;
      tx_data_q <= '0;
      tx_addr_q <= 1'b0;
      rx_ack_q <= 1'b0;
      pd_oe_q <= 1'b1;
      pd_out_q <= '0;
    end
    else
    begin
      mode_q <= mode_d;
      mask_q <= mask_d;
      dma_q <= dma_d;
      svc_q <= svc_d;
      dir_q <= dir_d;
      data_q <= data_d;
      ctrl_q <= ctrl_d;
      capb_q <= capb_d;
      fault_q <= peripheral_error_in_n;
      err_irq_q <= err_irq_d;
      svc_irq_q <= svc_irq_d;
      dma_req_q <= dma_req_d;
      epp_q <= epp_d;
      tx_valid_q <= tx_valid_d;
      tx_data_q <= tx_data_d;
      tx_addr_q <= tx_addr_d;
      rx_ack_q <= rx_ack_d;
      pd_oe_q <= pd_oe_d;
      pd_out_q <= pd_out_d;
    end
  end

  assign prdata = prdata_q;
  assign pready = pready_q;
  assign pslverr = pslverr_q;
  assign pd_out = pd_out_q;
  assign pd_oe = pd_oe_q;
  assign tx_valid = tx_valid_q;
  assign tx_data = tx_data_q;
  assign tx_is_addr = tx_addr_q;
  assign rx_ack = rx_ack_q;
  assign dma_req = dma_req_q;
  assign service_irq = svc_irq_q;
  assign error_irq = err_irq_q;
  assign epp_active = epp_q;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  a_ecr_always_ok: assert property (@(posedge clk_sys) disable iff (rst)
    (access && !pready_q && paddr == OFF_ECR) |=> (pready_q && !pslverr_q))
    else $error("extended control access refused");
  a_mode_write_taken: assert property (@(posedge clk_sys) disable iff (rst)
    (ecr_wr && wr_mode != MODE_RSVD) |=> (mode_q == $past(wr_mode)))
    else $error("mode write not stored");
  a_reserved_kept: assert property (@(posedge clk_sys) disable iff (rst)
    (ecr_wr && wr_mode == MODE_RSVD) |=> $stable(mode_q))
    else $error("reserved mode was stored");
  a_spp_fifo_reset: assert property (@(posedge clk_sys) disable iff (rst)
    (mode_d == MODE_SPP) |=> (fifo_empty && pd_oe_q))
    else $error("standard mode left FIFO or lines wrong");
  a_bidir_tristate: assert property (@(posedge clk_sys) disable iff (rst)
    (mode_q == MODE_BIDIR && dir_q && !ecr_wr && !wr_done) |=> !pd_oe_q)
    else $error("data lines driven in reverse direction");
  a_epp_active: assert property (@(posedge clk_sys) disable iff (rst)
    (mode_q == MODE_EPP && epp_selected) |=> epp_active)
    else $error("EPP not activated");
  a_test_no_send: assert property (@(posedge clk_sys) disable iff (rst)
    (mode_q == MODE_TEST && !tx_valid_q) |=> !tx_valid_q)
    else $error("test mode sent a byte");
  a_cap_a_value: assert property (@(posedge clk_sys) disable iff (rst)
    (access && !pready_q && mode_q == MODE_CFG && paddr == idx_addr(IDX_CAP_A))
    |=> (prdata_q[7:0] == CAP_A_VALUE && !pslverr_q))
    else $error("capability register A not mapped");
  a_err_irq_edge: assert property (@(posedge clk_sys) disable iff (rst)
    (mode_q == MODE_ECP && !mask_q && $fell(peripheral_error_in_n)) |=> error_irq)
    else $error("error edge not signalled");
  a_err_irq_masked: assert property (@(posedge clk_sys) disable iff (rst)
    mask_q |=> !error_irq)
    else $error("masked error edge signalled");
  a_svc_set_wins: assert property (@(posedge clk_sys) disable iff (rst)
    svc_event |=> (svc_q && service_irq))
    else $error("service event lost");
  a_flush_on_write: assert property (@(posedge clk_sys) disable iff (rst)
    (ecr_wr && wr_mode == MODE_SPP) |=> fifo_empty)
    else $error("FIFO not flushed on mode write");

endmodule

// [design/ppx_pkg.sv]
package ppx_pkg;

  // ----------------------------------------------------------------
  // Bus geometry and register offsets
  // ----------------------------------------------------------------
  localparam int ADDR_W = 13;
  localparam int DATA_W = 32;
  localparam logic [12:0] OFF_DATA = 13'h0000;
  localparam logic [12:0] OFF_CTRL = 13'h0004;
  localparam logic [12:0] OFF_ECR = 13'h0008;
  localparam logic [12:0] OFF_FIFO = 13'h000c;
  localparam logic [12:0] OFF_AQUEUE = 13'h0010;
  // Capability registers are kept as indices; byte address is four times the index.
  localparam logic [10:0] IDX_CAP_A = 11'h400;
  localparam logic [10:0] IDX_CAP_B = 11'h401;

  // ----------------------------------------------------------------
  // Field positions and reset values
  // ----------------------------------------------------------------
  localparam int ECR_MODE_LSB = 5;
  localparam int ECR_MASK_BIT = 4;
  localparam int ECR_DMA_BIT = 3;
  localparam int ECR_SVC_BIT = 2;
  localparam int ECR_FULL_BIT = 1;
  localparam int ECR_EMPTY_BIT = 0;
  localparam int CTRL_DIR_BIT = 5;
  localparam logic ECR_MASK_RST = 1'b1;
  localparam logic ECR_DMA_RST = 1'b0;
  localparam logic ECR_SVC_RST = 1'b1;
  localparam logic [7:0] CAP_A_VALUE = 8'h10;
  localparam logic [2:0] CAP_B_LOW_RST = 3'h7;
  localparam logic [2:0] CAP_B_IRQ_SEL = 3'h0;

  // ----------------------------------------------------------------
  // FIFO sizing and service threshold
  // ----------------------------------------------------------------
  localparam int FIFO_W = 9;
  localparam int FIFO_AW = 4;
  localparam int FIFO_DEPTH = 16;
  localparam logic [4:0] SVC_THRESH = 5'h08;

  typedef enum logic [2:0] {
    MODE_SPP = 3'h0,
    MODE_BIDIR = 3'h1,
    MODE_HWFIFO = 3'h2,
    MODE_ECP = 3'h3,
    MODE_EPP = 3'h4,
    MODE_RSVD = 3'h5,
    MODE_TEST = 3'h6,
    MODE_CFG = 3'h7
  } port_mode_t;

  typedef enum logic [1:0] {
    APB_IDLE = 2'b01,
    APB_DONE = 2'b10
  } apb_state_t;

endpackage

// [design/ppx_byte_fifo.sv]
`timescale 1ns/1ps

// ------------------------------------------------------------------
// Byte FIFO with tag bit, flip-flop storage and synchronous flush
// ------------------------------------------------------------------
module ppx_byte_fifo
  import ppx_pkg::*;
(
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic flush,
  input wire logic push,
  input wire logic [FIFO_W-1:0] push_data,
  input wire logic pop,
  output logic [FIFO_W-1:0] head,
  output logic full,
  output logic empty,
  output logic [FIFO_AW:0] count
);

  logic [FIFO_W-1:0] mem_q [FIFO_DEPTH];
  logic [FIFO_W-1:0] mem_d [FIFO_DEPTH];
  logic [FIFO_AW-1:0] wr_q, wr_d, rd_q, rd_d;
  logic [FIFO_AW:0] cnt_q, cnt_d;
  logic do_push, do_pop;

  // Pushes into a full FIFO and pops from an empty one are dropped.
  always_comb
  begin
    do_push = push && (cnt_q != FIFO_DEPTH[FIFO_AW:0]);
    do_pop = pop && (cnt_q != '0);
    wr_d = wr_q;
    rd_d = rd_q;
    cnt_d = cnt_q;
    for (int i = 0; i < FIFO_DEPTH; i++)
    begin
      mem_d[i] = mem_q[i];
    end
    if (flush)
    begin
      wr_d = '0;
      rd_d = '0;
      cnt_d = '0;
    end
    else
    begin
      if (do_push)
      begin
        mem_d[wr_q] = push_data;
        wr_d = wr_q + 4'h1;
      end
      if (do_pop)
      begin
        rd_d = rd_q + 4'h1;
      end
      cnt_d = cnt_q + {4'h0, do_push} - {4'h0, do_pop};
    end
  end

  // Storage and pointers.
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      wr_q <= '0;
      rd_q <= '0;
      cnt_q <= '0;
      for (int i = 0; i < FIFO_DEPTH; i++)
      begin
        mem_q[i] <= '0;
      end
    end
    else
    begin
      wr_q <= wr_d;
      rd_q <= rd_d;
      cnt_q <= cnt_d;
      for (int i = 0; i < FIFO_DEPTH; i++)
      begin
        mem_q[i] <= mem_d[i];
      end
    end
  end

  assign head = mem_q[rd_q];
  assign count = cnt_q;
  assign full = (cnt_q == FIFO_DEPTH[FIFO_AW:0]);
  assign empty = (cnt_q == '0);

endmodule

// [tb/ppx_printer_model.sv]
`timescale 1ns/1ps

// ----------------------------------------------------------------
// Peripheral model on the port side of the extended control block
// ----------------------------------------------------------------
module ppx_printer_model
  import ppx_pkg::*;
#(
  parameter logic [7:0] LINE_BYTE = 8'h5a
)
(
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic slow,
  input wire logic tx_valid,
  input wire logic [7:0] tx_data,
  input wire logic tx_is_addr,
  output logic tx_ack,
  output logic got_valid,
  output logic [8:0] got_byte,
  input wire logic send_valid,
  input wire logic [7:0] send_byte,
  output logic rx_valid,
  output logic [7:0] rx_data,
  input wire logic rx_ack,
  input wire logic fault_req,
  output logic peripheral_error_in_n,
  input wire logic [7:0] pd_out,
  input wire logic pd_oe,
  output logic [7:0] pd_in
);
  logic [1:0] stall_q;
  logic pend_q;
  logic [7:0] byte_q;

  // A byte is taken at once, or after a three-cycle stall when slow is set.
  assign tx_ack = tx_valid && (stall_q == 2'd0);
  // The offered byte is withdrawn in the acknowledge cycle, so it is never taken twice.
  assign rx_valid = pend_q && !rx_ack;
  // A released line shows the inverse of its last value, not a stale copy.
  assign rx_data = rx_valid ? byte_q : ~byte_q;
  // Lines float to a pattern of the peripheral's own when the port does not drive them.
  assign pd_in = pd_oe ? pd_out : LINE_BYTE;

  // Handshake state, receive byte and error line.
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      stall_q <= 2'd0;
      got_valid <= 1'b0;
      got_byte <= 9'h000;
      pend_q <= 1'b0;
      byte_q <= 8'h00;
      peripheral_error_in_n <= 1'b1;
    end
    else
    begin
      got_valid <= tx_ack;
      got_byte <= {tx_is_addr, tx_data};
      if (tx_ack)
        stall_q <= {slow, slow};
      else if (stall_q != 2'd0)
        stall_q <= stall_q - 2'd1;
      if (send_valid && !pend_q)
      begin
        pend_q <= 1'b1;
        byte_q <= send_byte;
      end
      else if (rx_ack)
        pend_q <= 1'b0;
      peripheral_error_in_n <= ~fault_req;
    end
  end
endmodule

// [tb/parallel_port_extended_control_bench.sv]
`timescale 1ns/1ps

module parallel_port_extended_control_bench
  import ppx_pkg::*;
;
  logic clk_sys, rst, psel, penable, pwrite, pready, pslverr, pd_oe, tx_valid, tx_is_addr, tx_ack;
  logic rx_valid, rx_ack, error_irq, epp_active, err_n, slow, send_valid, fault_req, got_valid;
  logic dma_req, service_irq, dma_tc, epp_sel;
  logic [12:0] paddr;
  logic [31:0] pwdata, prdata;
  logic [7:0] pd_in, pd_out, tx_data, rx_data, send_byte, b;
  logic [8:0] got_byte;
  logic [7:0] keep [16];
  logic [2:0] modes [7] = '{3'h0, 3'h1, 3'h2, 3'h3, 3'h4, 3'h6, 3'h7};
  logic [15:0] lfsr_q = 16'hfe2d;
  logic [8:0] rq [$];
  logic [8:0] txq [$];
  int failures = 0;
  int n_compared = 0;
  int n_err = 0;
  int n_svc = 0;
  int cycles = 0;

  parallel_port_extended_control i_dut (.clk_sys(clk_sys), .rst(rst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .peripheral_error_in_n(err_n), .epp_selected(epp_sel), .dma_tc(dma_tc), .irq_line(1'b0), .pd_in(pd_in),
    .pd_out(pd_out), .pd_oe(pd_oe), .tx_valid(tx_valid), .tx_data(tx_data), .tx_is_addr(tx_is_addr),
    .tx_ack(tx_ack), .rx_valid(rx_valid), .rx_data(rx_data), .rx_ack(rx_ack), .dma_req(dma_req),
    .service_irq(service_irq), .error_irq(error_irq), .epp_active(epp_active));

  ppx_printer_model i_model (.clk_sys(clk_sys), .rst(rst), .slow(slow), .tx_valid(tx_valid),
    .tx_data(tx_data), .tx_is_addr(tx_is_addr), .tx_ack(tx_ack), .got_valid(got_valid),
    .got_byte(got_byte), .send_valid(send_valid), .send_byte(send_byte), .rx_valid(rx_valid),
    .rx_data(rx_data), .rx_ack(rx_ack), .fault_req(fault_req), .peripheral_error_in_n(err_n),
    .pd_out(pd_out), .pd_oe(pd_oe), .pd_in(pd_in));

  // ----------------------------------------------------------------
  // Clock, timeout and shared helpers
  // ----------------------------------------------------------------
  // The clock toggles every half period of 20 ns.
  initial
  begin
    clk_sys = 1'b0;
    forever #20 clk_sys = ~clk_sys;
  end

  task automatic close_out();
    $display("compared %0d mismatches %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  task automatic chk(input logic [8:0] got, input logic [8:0] exp);
    n_compared++;
    if (got !== exp)
    begin
      failures++;
      $display("mismatch at %0t got %h expected %h", $time, got, exp);
    end
  endtask

  // Sixteen-bit shift register gives repeatable byte values.
  function automatic logic [7:0] rnd();
    lfsr_q = {lfsr_q[14:0], lfsr_q[15] ^ lfsr_q[13] ^ lfsr_q[12] ^ lfsr_q[10]};
    return lfsr_q[7:0];
  endfunction

  // One APB transfer; the trailing edge keeps two transfers from driving psel in one step.
  task automatic apb(input logic [12:0] a, input logic w, input logic [7:0] d);
    int n;
    n = 0;
    psel <= 1'b1;
    paddr <= a;
    pwrite <= w;
    pwdata <= {24'h000000, d};
    @(posedge clk_sys);
    penable <= 1'b1;
    @(posedge clk_sys);
    while (pready !== 1'b1 && n < 50)
    begin
      @(posedge clk_sys);
      n++;
    end
    // A slave that never answers counts as a mismatch.
    if (pready !== 1'b1)
      failures++;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk_sys);
  endtask

  task automatic rd(input logic [12:0] a, input logic [8:0] exp);
    rq.push_back(exp);
    apb(a, 1'b0, 8'h00);
  endtask

  task automatic wait_tx();
    int n;
    n = 0;
    while (txq.size() != 0 && n < 300)
    begin
      @(posedge clk_sys);
      n++;
    end
    if (n == 300)
      failures++;
  endtask

  task automatic send(input logic [7:0] v);
    int n;
    n = 0;
    send_valid <= 1'b1;
    send_byte <= v;
    @(posedge clk_sys);
    send_valid <= 1'b0;
    while (rx_ack !== 1'b1 && n < 50)
    begin
      @(posedge clk_sys);
      n++;
    end
    if (rx_ack !== 1'b1)
      failures++;
    @(posedge clk_sys);
  endtask

  task automatic fault();
    fault_req <= 1'b1;
    repeat (4) @(posedge clk_sys);
    fault_req <= 1'b0;
    repeat (4) @(posedge clk_sys);
  endtask

  // Watcher: read answers and port bytes are matched against the oldest note.
  always @(posedge clk_sys)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      failures++;
      close_out();
    end
    if ({psel, penable, pready, pwrite} === 4'b1110)
    begin
      if (rq.size() == 0)
        chk({pslverr, prdata[7:0]}, 9'h1ff);
      else
        chk({pslverr, prdata[7:0]}, rq.pop_front());
    end
    if (got_valid === 1'b1)
    begin
      if (txq.size() == 0)
        chk(got_byte, 9'h1ff);
      else
        chk(got_byte, txq.pop_front());
    end
    if (error_irq === 1'b1)
      n_err++;
    if (service_irq === 1'b1)
      n_svc++;
  end

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial
  begin
    rst = 1'b1;
    {psel, penable, pwrite, slow, send_valid, fault_req, epp_sel, dma_tc} = 8'h00;
    paddr = 13'h0000;
    pwdata = 32'h00000000;
    send_byte = 8'h00;
    repeat (2) @(posedge clk_sys);
    rst <= 1'b0;
    @(posedge clk_sys);
    rd(OFF_ECR, 9'h015);
    apb(OFF_CTRL, 1'b1, 8'h00);
    // EPP mode with another port type chosen must stay inactive.
    apb(OFF_ECR, 1'b1, 8'h95);
    repeat (2) @(posedge clk_sys);
    chk({8'h00, epp_active}, 9'h000);
    epp_sel <= 1'b1;
    foreach (modes[i])
    begin
      apb(OFF_ECR, 1'b1, {modes[i], 5'h15});
      rd(OFF_ECR, {1'b0, modes[i], 5'h15});
      chk({8'h00, epp_active}, {8'h00, modes[i] == 3'h4});
    end
    apb(OFF_ECR, 1'b1, 8'hb5);
    rd(OFF_ECR, 9'h0f5);
    rd({IDX_CAP_A, 2'b00}, 9'h010);
    rd({IDX_CAP_B, 2'b00}, 9'h007);
    apb(OFF_ECR, 1'b1, 8'hd5);
    rd({IDX_CAP_A, 2'b00}, 9'h100);
    // Test mode: fill to full, drain to empty, nothing may reach the port.
    for (int i = 0; i < 16; i++)
    begin
      keep[i] = rnd();
      apb(OFF_FIFO, 1'b1, keep[i]);
    end
    rd(OFF_ECR, 9'h0d6);
    for (int i = 0; i < 16; i++)
      rd(OFF_FIFO, {1'b0, keep[i]});
    rd(OFF_ECR, 9'h0d5);
    for (int i = 0; i < 3; i++)
      apb(OFF_FIFO, 1'b1, rnd());
    apb(OFF_ECR, 1'b1, 8'h15);
    rd(OFF_ECR, 9'h015);
    chk({8'h00, pd_oe}, 9'h001);
    apb(OFF_DATA, 1'b1, 8'ha6);
    chk({1'b0, pd_out}, 9'h0a6);
    // Forward sends with a stalling, then a prompt, peripheral.
    slow <= 1'b1;
    apb(OFF_ECR, 1'b1, 8'h55);
    for (int i = 0; i < 5; i++)
    begin
      b = rnd();
      txq.push_back({1'b0, b});
      apb(OFF_FIFO, 1'b1, b);
    end
    wait_tx();
    slow <= 1'b0;
    apb(OFF_ECR, 1'b1, 8'h75);
    for (int i = 0; i < 3; i++)
    begin
      b = rnd();
      txq.push_back({i == 1, b});
      apb((i == 1) ? OFF_AQUEUE : OFF_FIFO, 1'b1, b);
    end
    wait_tx();
    // Reverse direction: peripheral bytes land in the queue for the host.
    apb(OFF_CTRL, 1'b1, 8'h20);
    for (int i = 0; i < 3; i++)
    begin
      keep[i] = rnd();
      send(keep[i]);
    end
    for (int i = 0; i < 3; i++)
      rd(OFF_FIFO, {1'b0, keep[i]});
    apb(OFF_ECR, 1'b1, 8'h65);
    fault();
    chk(9'(n_err), 9'h001);
    apb(OFF_ECR, 1'b1, 8'h75);
    fault();
    chk(9'(n_err), 9'h001);
    // Bidirectional mode with the lines released reads back the live lines.
    apb(OFF_ECR, 1'b1, 8'h35);
    repeat (2) @(posedge clk_sys);
    chk({8'h00, pd_oe}, 9'h000);
    rd(OFF_DATA, 9'h05a);
    apb(OFF_ECR, 1'b1, 8'h39);
    rd(OFF_ECR, 9'h039);
    apb(OFF_CTRL, 1'b1, 8'h00);
    // Test mode with DMA on: requests flow until terminal count sets the service flag.
    apb(OFF_ECR, 1'b1, 8'hd8);
    rd(OFF_ECR, 9'h0d9);
    chk({8'h00, dma_req}, 9'h001);
    dma_tc <= 1'b1;
    @(posedge clk_sys);
    dma_tc <= 1'b0;
    rd(OFF_ECR, 9'h0dd);
    chk({8'h00, dma_req}, 9'h000);
    // Clearing the flag with DMA off lets the free-space threshold set it again.
    apb(OFF_ECR, 1'b1, 8'hd1);
    rd(OFF_ECR, 9'h0d5);
    chk(9'(n_svc), 9'h002);
    close_out();
  end
endmodule
